/* inc/coupler_defs.svh */
// Register numbers, field positions, codes and reset values of the status bank
`ifndef COUPLER_DEFS_SVH
`define COUPLER_DEFS_SVH

// Holding register numbers
`define REG_DIAG 16'h0384
`define REG_MOD_FLAGS 16'h0385
`define REG_STAT_LO 16'h03a2
`define REG_STAT_HI 16'h03a3
`define REG_SYS_STATE 16'h03a4
`define REG_BUS_CFG 16'h03a5
`define REG_RX_COUNT 16'h03df
`define REG_TX_COUNT 16'h03e0

// Field positions
`define DIAG_RUN_BIT 9
`define DIAG_CFG_BIT 13
`define CFG_CONSIST_BIT 0
`define NUM_MODULES 14

// Reset values
`define BUS_CFG_RESET 16'h0000
`define COUNT_RESET 16'h0000

// Module and bus status codes
`define ST_OK 2'h0
`define ST_CFG_ERR 2'h1
`define ST_RUN_ERR 2'h2
`define ST_ABSENT 2'h3

// System state codes
`define SS_BOOT 4'h0
`define SS_UNCONF 4'h1
`define SS_XFER 4'h2
`define SS_APPLIED 4'h3
`define SS_EIP 4'h4
`define SS_SCAN 4'h5
`define SS_WEB 4'h6
`define SS_TIMEOUT 4'h7
`define SS_FWUPD 4'h8
`define SS_TRANS 4'ha

// I/O value zones, inclusive bounds
`define ZIN_LO 16'h0001
`define ZIN_HI 16'h0063
`define ZOUT_LO 16'h0065
`define ZOUT_HI 16'h00c7
`define ZALLIN_LO 16'h0bb9
`define ZALLIN_HI 16'h0dab
`define ZALLOUT_LO 16'h0dad
`define ZALLOUT_HI 16'h0f9f
`define ZHMI_LO 16'h32c9
`define ZHMI_HI 16'h3677

`endif

/* inc/coupler_pkg.sv */
// Types shared by the status bank and its system state tracker
package coupler_pkg;
   // System states
   typedef enum logic [3:0] {
      SYS_BOOT, SYS_UNCONF, SYS_XFER, SYS_APPLIED, SYS_EIP,
      SYS_SCAN, SYS_WEB, SYS_TIMEOUT, SYS_FWUPD, SYS_TRANS
   } sys_state_t;
   // Party that controls the expansion bus
   typedef enum logic [1:0] {
      OWN_NONE, OWN_EIP, OWN_SCAN, OWN_WEB
   } bus_owner_t;
endpackage

/* inc/state_if.sv */
// Events into the system state tracker and the state it reports
`timescale 1ns/1ps
interface state_if;
   import coupler_pkg::*;
   logic boot_done;
   logic fw_update;
   logic transition;
   logic refresh_timeout;
   logic cfg_xfer;
   logic cfg_applied;
   bus_owner_t owner;
   sys_state_t state;
   modport src (output boot_done, fw_update, transition, refresh_timeout,
                output cfg_xfer, cfg_applied, owner, input state);
   modport fsm (input boot_done, fw_update, transition, refresh_timeout,
                input cfg_xfer, cfg_applied, owner, output state);
endinterface

/* hdl/sys_state_fsm.sv */
// System state tracker of the coupler
`timescale 1ns/1ps
module sys_state_fsm (
   // Clock and synchronised reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Events and state
   state_if.fsm sif
);
   import coupler_pkg::*;

   sys_state_t state_d, state_q;
   logic booted_d, booted_q;

   // Next state; maintenance states override everything
   always_comb begin
      booted_d = booted_q | sif.boot_done;
      state_d = SYS_UNCONF;
      if (sif.fw_update) begin
         state_d = SYS_FWUPD;
      end else if (sif.transition) begin
         state_d = SYS_TRANS;
      end else if (!booted_q) begin
         state_d = SYS_BOOT;
      end else if (sif.refresh_timeout) begin
         state_d = SYS_TIMEOUT;
      end else begin
         case (sif.owner)
            OWN_EIP: begin
               state_d = SYS_EIP;
            end
            OWN_SCAN: begin
               state_d = SYS_SCAN;
            end
            OWN_WEB: begin
               state_d = SYS_WEB;
            end
            default: begin
               if (sif.cfg_xfer) begin
                  state_d = SYS_XFER;
               end else if (sif.cfg_applied) begin
                  state_d = SYS_APPLIED;
               end
            end
         endcase
      end
   end

   // State registers
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= SYS_BOOT;
         booted_q <= 1'b0;
      end else begin
         state_q <= state_d;
         booted_q <= booted_d;
      end
   end

   assign sif.state = state_q;
endmodule

/* hdl/coupler_status_registers.sv */
// Status and diagnostic holding register bank of the bus coupler
//
// Contract
// - Diagnostic bit 9 is set while the expansion bus has a runtime error.
// - Diagnostic bit 13 is set when the bus is unconfigured or misconfigured.
// - Error flags register: one bit per module 1 to 14, one means error.
// - Two status bits per module; modules 9-14 in the upper status word.
// - Module status codes: ok, config error, runtime error, optional absent.
// - Upper status word bits 14-15 give the overall bus status.
// - System state reads boot, unconfigured or configuration transfer codes.
// - Applied configuration reports state 3 and forces all outputs to zero.
// - States 4, 5, 6 name the bus owner: adapter, scanner, web server.
// - State 7 reports a fieldbus refresh timeout.
// - State 8 is firmware update, state 0xA a state transition.
// - Bus configuration bit 0 enables data consistency.
// - While the server is enabled the status registers follow live state.
// - Received message counter register counts messages received.
// - Sent message counter register counts messages sent.
// - I/O zone accesses answer an error unless the system state is 5.
`timescale 1ns/1ps
`include "coupler_defs.svh"
module coupler_status_registers (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Server enable and message events
   input wire logic i_modbus_en,
   input wire logic i_msg_rx,
   input wire logic i_msg_tx,
   // Expansion bus status
   input wire logic [1:0] i_bus_status,
   input wire logic [27:0] i_mod_status,
   // System events
   input wire logic i_boot_done,
   input wire logic i_fw_update,
   input wire logic i_transition,
   input wire logic i_refresh_timeout,
   input wire logic i_cfg_xfer,
   input wire logic i_cfg_applied,
   input wire coupler_pkg::bus_owner_t i_owner,
   // Register access request
   input wire logic i_acc_req,
   input wire logic i_acc_write,
   input wire logic [15:0] i_acc_addr,
   input wire logic [15:0] i_acc_wdata,
   // Register access answer
   output logic o_acc_ack,
   output logic o_acc_err,
   output logic [15:0] o_acc_rdata,
   // Controls to the coupler
   output logic o_data_consist,
   output logic o_outputs_zero
);
   import coupler_pkg::*;

   // Reset synchroniser
   logic [1:0] rst_sync_d, rst_sync_q;
   logic rst_n;

   // Status snapshot
   logic [15:0] diag_d, diag_q;
   logic [15:0] flags_d, flags_q;
   logic [15:0] stat_lo_d, stat_lo_q;
   logic [15:0] stat_hi_d, stat_hi_q;
   logic [15:0] sys_d, sys_q;

   // Configuration and counters
   logic [15:0] cfg_d, cfg_q;
   logic [15:0] rx_cnt_d, rx_cnt_q;
   logic [15:0] tx_cnt_d, tx_cnt_q;

   // Access answer
   logic ack_d, ack_q;
   logic err_d, err_q;
   logic [15:0] rdata_d, rdata_q;
   logic zero_d, zero_q;

   // System state tracker
   state_if sif ();
   sys_state_t state;

   // A module flags an error only for config or runtime faults
   function automatic logic mod_err(input logic [1:0] st);
      mod_err = (st == `ST_CFG_ERR) || (st == `ST_RUN_ERR);
   endfunction

   // Inclusive range test, used for every I/O zone
   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // Register number falls in one of the I/O value zones
   function automatic logic io_zone(input logic [15:0] a);
      io_zone = in_range(a, `ZIN_LO, `ZIN_HI) ||
                in_range(a, `ZOUT_LO, `ZOUT_HI) ||
                in_range(a, `ZALLIN_LO, `ZALLIN_HI) ||
                in_range(a, `ZALLOUT_LO, `ZALLOUT_HI) ||
                in_range(a, `ZHMI_LO, `ZHMI_HI);
   endfunction

   // Numeric code of each system state
   function automatic logic [3:0] state_code(input sys_state_t s);
      case (s)
         SYS_BOOT: state_code = `SS_BOOT;
         SYS_UNCONF: state_code = `SS_UNCONF;
         SYS_XFER: state_code = `SS_XFER;
         SYS_APPLIED: state_code = `SS_APPLIED;
         SYS_EIP: state_code = `SS_EIP;
         SYS_SCAN: state_code = `SS_SCAN;
         SYS_WEB: state_code = `SS_WEB;
         SYS_TIMEOUT: state_code = `SS_TIMEOUT;
         SYS_FWUPD: state_code = `SS_FWUPD;
         SYS_TRANS: state_code = `SS_TRANS;
         default: state_code = `SS_BOOT;
      endcase
   endfunction

   // Reset release shifts in ones; assertion stays asynchronous
   always_comb begin
      rst_sync_d = {rst_sync_q[0], 1'b1};
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= rst_sync_d;
      end
   end

   assign rst_n = rst_sync_q[1];

   // Events handed to the state tracker
   assign sif.boot_done = i_boot_done;
   assign sif.fw_update = i_fw_update;
   assign sif.transition = i_transition;
   assign sif.refresh_timeout = i_refresh_timeout;
   assign sif.cfg_xfer = i_cfg_xfer;
   assign sif.cfg_applied = i_cfg_applied;
   assign sif.owner = i_owner;
   assign state = sif.state;

   sys_state_fsm u_state (
      .i_clk (i_sys_clk),
      .i_rst_n (rst_n),
      .sif (sif)
   );

   // Status snapshot; frozen while the server is disabled
   always_comb begin
      diag_d = diag_q;
      flags_d = flags_q;
      stat_lo_d = stat_lo_q;
      stat_hi_d = stat_hi_q;
      sys_d = sys_q;
      if (i_modbus_en) begin
         diag_d = 16'h0000;
         diag_d[`DIAG_RUN_BIT] = (i_bus_status == `ST_RUN_ERR);
         diag_d[`DIAG_CFG_BIT] = (i_bus_status == `ST_CFG_ERR) ||
                                 (i_bus_status == `ST_ABSENT);
         flags_d = 16'h0000;
         for (int i = 0; i < `NUM_MODULES; i++) begin
            flags_d[i] = mod_err(i_mod_status[2*i +: 2]);
         end
         // Modules 1 to 8, bit pair per module
         stat_lo_d = i_mod_status[15:0];
         // Bus status on top, reserved pair held at zero
         stat_hi_d = {i_bus_status, 2'b00, i_mod_status[27:16]};
         sys_d = {12'h000, state_code(state)};
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         diag_q <= 16'h0000;
         flags_q <= 16'h0000;
         stat_lo_q <= 16'h0000;
         stat_hi_q <= 16'h0000;
         sys_q <= 16'h0000;
      end else begin
         diag_q <= diag_d;
         flags_q <= flags_d;
         stat_lo_q <= stat_lo_d;
         stat_hi_q <= stat_hi_d;
         sys_q <= sys_d;
      end
   end

   // Message counters wrap silently; software takes differences
   always_comb begin
      rx_cnt_d = rx_cnt_q;
      tx_cnt_d = tx_cnt_q;
      if (i_msg_rx) begin
         rx_cnt_d = rx_cnt_q + 16'h0001;
      end
      if (i_msg_tx) begin
         tx_cnt_d = tx_cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_cnt_q <= `COUNT_RESET;
         tx_cnt_q <= `COUNT_RESET;
      end else begin
         rx_cnt_q <= rx_cnt_d;
         tx_cnt_q <= tx_cnt_d;
      end
   end

   // Register decode and answer; writes to read-only words are dropped
   always_comb begin
      ack_d = i_acc_req;
      err_d = err_q;
      rdata_d = rdata_q;
      if (i_acc_req) begin
         err_d = 1'b0;
         rdata_d = 16'h0000;
         case (i_acc_addr)
            `REG_DIAG: begin
               rdata_d = diag_q;
            end
            `REG_MOD_FLAGS: begin
               rdata_d = flags_q;
            end
            `REG_STAT_LO: begin
               rdata_d = stat_lo_q;
            end
            `REG_STAT_HI: begin
               rdata_d = stat_hi_q;
            end
            `REG_SYS_STATE: begin
               rdata_d = sys_q;
            end
            `REG_BUS_CFG: begin
               // A write answers with the value it leaves behind
               rdata_d = cfg_d;
            end
            `REG_RX_COUNT: begin
               rdata_d = rx_cnt_q;
            end
            `REG_TX_COUNT: begin
               rdata_d = tx_cnt_q;
            end
            default: begin
               // I/O data lives outside this bank; zones read zero here
               if (io_zone(i_acc_addr)) begin
                  err_d = (state != SYS_SCAN);
               end else begin
                  err_d = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         ack_q <= ack_d;
         err_q <= err_d;
         rdata_q <= rdata_d;
      end
   end

   // Bus configuration; only the consistency bit survives a write
   always_comb begin
      cfg_d = cfg_q;
      if (i_acc_req && i_acc_write && (i_acc_addr == `REG_BUS_CFG)) begin
         cfg_d = 16'h0000;
         cfg_d[`CFG_CONSIST_BIT] = i_acc_wdata[`CFG_CONSIST_BIT];
      end
   end

   // Kept across server disable; only reset or a bus configuration write changes the choice
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= `BUS_CFG_RESET;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // Outputs are forced to zero only in the applied state
   always_comb begin
      zero_d = (state == SYS_APPLIED);
   end

   // One edge behind the tracker, so it lines up with the state word
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         zero_q <= 1'b0;
      end else begin
         zero_q <= zero_d;
      end
   end

   // Every output straight from a flip-flop
   assign o_acc_ack = ack_q;
   assign o_acc_err = err_q;
   assign o_acc_rdata = rdata_q;
   assign o_data_consist = cfg_q[`CFG_CONSIST_BIT];
   assign o_outputs_zero = zero_q;
endmodule

/* sim/coupler_status_assertions.sv */
// Port-level checks of the coupler status register bank
`timescale 1ns/1ps
`include "coupler_defs.svh"
module coupler_status_assertions (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Watched inputs
   input wire logic i_modbus_en,
   input wire logic [1:0] i_bus_status,
   input wire logic [27:0] i_mod_status,
   input wire logic i_fw_update,
   input wire logic i_acc_req,
   input wire logic i_acc_write,
   input wire logic [15:0] i_acc_addr,
   input wire logic [15:0] i_acc_wdata,
   // Watched outputs
   input wire logic o_acc_ack,
   input wire logic o_acc_err,
   input wire logic [15:0] o_acc_rdata,
   input wire logic o_data_consist
);
   logic rd;
   logic [15:0] flg;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   // Live read qualifier; callers add input stability
   assign rd = i_acc_req && !i_acc_write && i_modbus_en;
   // Error flag expected per module: codes 1 and 2 only
   always_comb begin
      flg = 16'h0000;
      for (int k = 0; k < 14; k++) flg[k] = i_mod_status[2*k] ^ i_mod_status[2*k+1];
   end
   diag_bits_a: assert property (rd && $past(i_modbus_en) && $stable(i_bus_status) &&
      i_acc_addr == `REG_DIAG |=> o_acc_rdata ==
      {2'b00, $past(i_bus_status[0]), 3'b000, $past(i_bus_status) == 2'h2, 9'h000})
      else $error("diagnostic word wrong");
   error_flags_a: assert property (rd && $past(i_modbus_en) && $stable(i_mod_status) &&
      i_acc_addr == `REG_MOD_FLAGS |=> o_acc_rdata == $past(flg)) else $error("flag word wrong");
   status_low_a: assert property (rd && $past(i_modbus_en) && $stable(i_mod_status) &&
      i_acc_addr == `REG_STAT_LO |=> o_acc_rdata == $past(i_mod_status[15:0])) else $error("low status wrong");
   status_high_a: assert property (rd && $past(i_modbus_en) && $stable(i_mod_status) &&
      $stable(i_bus_status) && i_acc_addr == `REG_STAT_HI |=> o_acc_rdata ==
      {$past(i_bus_status), 2'b00, $past(i_mod_status[27:16])}) else $error("high status wrong");
   state_upper_a: assert property (i_acc_req && !i_acc_write && i_acc_addr == `REG_SYS_STATE
      |=> o_acc_rdata[15:4] == 12'h000) else $error("state upper bits set");
   cfg_write_a: assert property (i_acc_req && i_acc_write && i_acc_addr == `REG_BUS_CFG |=>
      o_data_consist == $past(i_acc_wdata[0]) && o_acc_rdata == {15'h0000, $past(i_acc_wdata[0])})
      else $error("configuration write wrong");
   zone_refuse_a: assert property (i_acc_req && i_fw_update && $past(i_fw_update) &&
      i_acc_addr == `ZIN_LO |=> o_acc_ack && o_acc_err) else $error("zone access not refused");
   unmapped_addr_a: assert property (i_acc_req && i_acc_addr == 16'h0000 |=>
      o_acc_err && o_acc_rdata == 16'h0000) else $error("unmapped access not refused");
   ack_timing_a: assert property (o_acc_ack == $past(i_acc_req)) else $error("answer timing wrong");
   answer_hold_a: assert property (!o_acc_ack |-> $stable(o_acc_rdata) && $stable(o_acc_err))
      else $error("answer changed between acks");
endmodule
bind coupler_status_registers coupler_status_assertions coupler_status_assertions_i (
   .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_modbus_en(i_modbus_en),
   .i_bus_status(i_bus_status), .i_mod_status(i_mod_status), .i_fw_update(i_fw_update),
   .i_acc_req(i_acc_req), .i_acc_write(i_acc_write), .i_acc_addr(i_acc_addr), .i_acc_wdata(i_acc_wdata),
   .o_acc_ack(o_acc_ack), .o_acc_err(o_acc_err), .o_acc_rdata(o_acc_rdata), .o_data_consist(o_data_consist));

/* sim/modbus_client_model.sv */
// Remote client model issuing single-word register accesses
`timescale 1ns/1ps
module modbus_client_model (
   // Clock
   input wire logic i_clk,
   // Answer from the bank
   input wire logic i_ack,
   input wire logic i_err,
   input wire logic [15:0] i_rdata,
   // Request to the bank
   output logic o_req = 1'b0,
   output logic o_write = 1'b0,
   output logic [15:0] o_addr = 16'hffff,
   output logic [15:0] o_wdata = 16'h0000
);
   // One access: one-cycle request, answer taken while ack stands
   task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                         output logic [15:0] q, output logic e);
      int n;
      n = 0;
      @(negedge i_clk);
      o_req = 1'b1;
      o_write = wr;
      o_addr = a;
      o_wdata = d;
      @(negedge i_clk);
      // Released lines show the inverse so stale values never match
      o_req = 1'b0;
      o_write = ~wr;
      o_addr = ~a;
      o_wdata = ~d;
      while (i_ack !== 1'b1 && n < 8) begin
         @(negedge i_clk);
         n++;
      end
      q = (n < 8) ? i_rdata : 16'hxxxx;
      e = (n < 8) ? i_err : 1'bx;
   endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench of the coupler status register bank
`timescale 1ns/1ps
`include "coupler_defs.svh"
module tb_top;
   import coupler_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic en = 1'b0;
   logic rx = 1'b0;
   logic tx = 1'b0;
   logic boot = 1'b0;
   logic fw = 1'b0;
   logic trans = 1'b0;
   logic tmo = 1'b0;
   logic xfer = 1'b0;
   logic app = 1'b0;
   logic [1:0] bus = 2'h0;
   logic [27:0] mods = 28'h0000000;
   bus_owner_t own = OWN_NONE;
   logic req, wr_en, ack, err, consist, ozero;
   logic [15:0] addr, wdata, rdata;
   int fail_count = 0;
   int n_checks = 0;
   // Stimulus table {fw, trans, timeout, xfer, applied, owner} and state codes
   logic [6:0] stim [10] = '{7'h00, 7'h08, 7'h04, 7'h01, 7'h02, 7'h03, 7'h10, 7'h40, 7'h20, 7'h7f};
   logic [3:0] codes [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'h8};
   coupler_status_registers coupler_status_registers_i (.i_sys_clk(clk), .i_reset_n(rst_n),
      .i_modbus_en(en), .i_msg_rx(rx), .i_msg_tx(tx), .i_bus_status(bus), .i_mod_status(mods),
      .i_boot_done(boot), .i_fw_update(fw), .i_transition(trans), .i_refresh_timeout(tmo),
      .i_cfg_xfer(xfer), .i_cfg_applied(app), .i_owner(own), .i_acc_req(req), .i_acc_write(wr_en),
      .i_acc_addr(addr), .i_acc_wdata(wdata), .o_acc_ack(ack), .o_acc_err(err), .o_acc_rdata(rdata),
      .o_data_consist(consist), .o_outputs_zero(ozero));
   modbus_client_model modbus_client_model_i (.i_clk(clk), .i_ack(ack), .i_err(err), .i_rdata(rdata),
      .o_req(req), .o_write(wr_en), .o_addr(addr), .o_wdata(wdata));
   // Clock of 4 ns
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   // Read; data is judged only when no refusal is expected
   task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic exp_err);
      logic [15:0] q;
      logic e;
      modbus_client_model_i.access(1'b0, a, 16'h0000, q, e);
      chk({15'h0000, e}, {15'h0000, exp_err});
      if (!exp_err) chk(q, exp);
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      logic [15:0] q;
      logic e;
      modbus_client_model_i.access(1'b1, a, d, q, e);
      chk({15'h0000, e}, 16'h0000);
   endtask
   // Server enabled before boot ends, so the state word is live
   task automatic t_boot();
      en = 1'b1;
      repeat (2) @(negedge clk);
      rd(`REG_SYS_STATE, 16'h0000, 1'b0);
      rd(`REG_BUS_CFG, 16'h0000, 1'b0);
   endtask
   // Every bus code, module codes rotated through all four values
   task automatic t_status();
      logic [15:0] f;
      en = 1'b1;
      boot = 1'b1;
      for (int b = 0; b < 4; b++) begin
         bus = 2'(b);
         f = 16'h0000;
         for (int k = 0; k < 14; k++) mods[2*k +: 2] = 2'(k + b);
         for (int k = 0; k < 14; k++) f[k] = (2'(k + b) == 2'h1) || (2'(k + b) == 2'h2);
         repeat (2) @(negedge clk);
         rd(`REG_DIAG, {2'b00, bus[0], 3'b000, bus == 2'h2, 9'h000}, 1'b0);
         rd(`REG_MOD_FLAGS, f, 1'b0);
         rd(`REG_STAT_LO, mods[15:0], 1'b0);
         rd(`REG_STAT_HI, {bus, 2'b00, mods[27:16]}, 1'b0);
      end
      wr(`REG_STAT_LO, ~mods[15:0]);
      rd(`REG_STAT_LO, mods[15:0], 1'b0);
   endtask
   // Disabled server freezes the words; enabling again refreshes them
   task automatic t_freeze();
      en = 1'b0;
      bus = 2'h0;
      repeat (2) @(negedge clk);
      rd(`REG_STAT_HI, {2'h3, 2'b00, mods[27:16]}, 1'b0);
      en = 1'b1;
      repeat (2) @(negedge clk);
      rd(`REG_STAT_HI, {2'h0, 2'b00, mods[27:16]}, 1'b0);
   endtask
   task automatic t_state();
      for (int k = 0; k < 10; k++) begin
         fw = stim[k][6];
         trans = stim[k][5];
         tmo = stim[k][4];
         xfer = stim[k][3];
         app = stim[k][2];
         own = bus_owner_t'(stim[k][1:0]);
         repeat (3) @(negedge clk);
         rd(`REG_SYS_STATE, {12'h000, codes[k]}, 1'b0);
         chk({15'h0000, ozero}, {15'h0000, codes[k] == 4'h3});
         rd(`ZIN_LO, 16'h0000, codes[k] != 4'h5);
         rd(`ZHMI_HI, 16'h0000, codes[k] != 4'h5);
         rd(`ZOUT_LO, 16'h0000, codes[k] != 4'h5);
         rd(`ZALLIN_HI, 16'h0000, codes[k] != 4'h5);
         rd(`ZALLOUT_LO, 16'h0000, codes[k] != 4'h5);
         rd(`ZHMI_LO, 16'h0000, codes[k] != 4'h5);
         rd(16'h0064, 16'h0000, 1'b1);
      end
   endtask
   task automatic t_cfg();
      wr(`REG_BUS_CFG, 16'hffff);
      chk({15'h0000, consist}, 16'h0001);
      rd(`REG_BUS_CFG, 16'h0001, 1'b0);
      wr(`REG_BUS_CFG, 16'hfffe);
      chk({15'h0000, consist}, 16'h0000);
   endtask
   // Back-to-back message pulses: five received, three sent
   task automatic t_count();
      for (int k = 0; k < 5; k++) begin
         rx = 1'b1;
         tx = (k < 3);
         @(negedge clk);
      end
      rx = 1'b0;
      tx = 1'b0;
      rd(`REG_RX_COUNT, 16'h0005, 1'b0);
      rd(`REG_TX_COUNT, 16'h0003, 1'b0);
      rd(16'h0000, 16'h0000, 1'b1);
      rd(16'h0386, 16'h0000, 1'b1);
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Main sequence after three reset cycles
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_boot();
      t_status();
      t_freeze();
      t_state();
      t_cfg();
      t_count();
      tally_and_finish();
   end
   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #(20000 * 4);
      fail_count++;
      tally_and_finish();
   end
endmodule
